//--- timer_cfg.svh
// constants for the event-reset timer: register offsets, field positions, reset values
// assumes a 32-bit axi4-lite slave with one register per aligned word
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

`define OFS_TIMER_CONTROL   8'h00
`define OFS_GATE_CONTROL    8'h04
`define OFS_COUNT_LOW       8'h08
`define OFS_COUNT_HIGH      8'h0C
`define OFS_COMPARE_LOW     8'h10
`define OFS_COMPARE_HIGH    8'h14
`define OFS_COMPARE_CONTROL 8'h18
`define OFS_IRQ_STATUS      8'h1C
`define OFS_IRQ_MASK        8'h20

`define TC_ENABLE_BIT       0
`define TC_SOURCE_BIT       1
`define TC_PRESCALE_LSB     4
`define TC_PRESCALE_MSB     5
`define TC_WRITE_MASK       8'h33

`define GC_SOURCE_LSB       0
`define GC_SOURCE_MSB       1
`define GC_VALUE_BIT        2
`define GC_GO_BIT           3
`define GC_SPM_BIT          4
`define GC_TOGGLE_BIT       5
`define GC_POLARITY_BIT     6
`define GC_ENABLE_BIT       7

`define CC_COMPARE_BIT      0
`define CC_SPECIAL_BIT      1

`define IRQ_OVERFLOW_BIT    0
`define IRQ_GATE_BIT        1
`define IRQ_COMPARE_BIT     2
`define IRQ_WIDTH           3

`define RESET_BYTE          8'h00
`define RESET_WORD          16'h0000
`define RESET_IRQ           3'h0
`define COUNT_MAX           16'hFFFF
`define INST_DIV_LAST       2'h3

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

//--- timer_pkg.sv
// types shared by the event-reset timer files
// assumes timer_cfg.svh for numeric constants
`default_nettype none

package timer_pkg;

    typedef enum logic [1:0] {
        prescale_1 = 2'h0,
        prescale_2 = 2'h1,
        prescale_4 = 2'h2,
        prescale_8 = 2'h3
    } prescale_t;

    typedef enum logic [1:0] {
        gate_from_pin1     = 2'h0,
        gate_from_timer0   = 2'h1,
        gate_from_pin2     = 2'h2,
        gate_from_uv_comp  = 2'h3
    } gate_source_t;

endpackage

`default_nettype wire

//--- timer_prescaler.sv
// counter clock prescaler: passes one in 1, 2, 4 or 8 input ticks
// assumes tick_in is a one-cycle enable in the aclk domain
`include "timer_cfg.svh"
`default_nettype none

module timer_prescaler
    import timer_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    input  wire logic  clear,
    input  wire logic  tick_in,
    input  wire prescale_t ratio,
    output logic       tick_out
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] mask;

    always_comb begin
        unique case (ratio)
            prescale_1: mask = WIDTH'(0);
            prescale_2: mask = WIDTH'(1);
            prescale_4: mask = WIDTH'(3);
            prescale_8: mask = WIDTH'(7);
        endcase
    end

    // hidden count, never visible to software
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            count <= '0;
        end else if (tick_in) begin
            count <= count + WIDTH'(1);
        end
    end

    assign tick_out = tick_in && ((count & mask) == mask);

endmodule

`default_nettype wire

//--- timer_event_reset.sv
// 16-bit up-counter with prescaler, gate logic, compare unit and special event clear
// assumes aclk is the system clock; gate inputs synchronous to aclk; axi4-lite master
`include "timer_cfg.svh"
`default_nettype none

module timer_event_reset
    import timer_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        gate_pin1,
    input  wire logic        gate_pin2,
    input  wire logic        timer0_overflow,
    input  wire logic        uv_comparator,
    input  wire logic        special_event_in,
    output logic             special_event_out,
    output logic [15:0]      count_value,
    output logic             irq
);

    // register state
    logic [7:0]           timer_control;
    logic                 gate_enable;
    logic                 gate_polarity;
    logic                 toggle_mode;
    logic                 single_pulse_mode;
    logic                 pulse_acquire_go;
    gate_source_t         gate_source;
    logic                 gate_level_value;
    logic [7:0]           count_low_byte;
    logic [7:0]           count_high_byte;
    logic [7:0]           compare_value_low;
    logic [7:0]           compare_value_high;
    logic                 compare_mode;
    logic                 special_event_enable;
    logic [`IRQ_WIDTH-1:0] irq_status;
    logic [`IRQ_WIDTH-1:0] irq_mask;

    // bus state
    logic                 aw_held;
    logic [7:0]           aw_addr;
    logic                 w_held;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;

    // derived
    logic                 counter_enable;
    logic                 clock_source_select;
    prescale_t            prescale_select;
    logic [1:0]           inst_div;
    logic                 inst_tick;
    logic                 source_tick;
    logic                 count_tick;
    logic                 gate_raw;
    logic                 gate_active;
    logic                 gate_active_q;
    logic                 gate_toggle;
    logic                 next_gate_level;
    logic                 gate_fall;
    logic [15:0]          count;
    logic [15:0]          compare_value;
    logic                 match;
    logic                 match_q;
    logic                 compare_event;
    logic                 special_clear;
    logic                 do_write;
    logic                 write_low;
    logic                 write_high;
    logic                 write_gate;
    logic                 count_write;
    logic                 may_count;
    logic                 overflow_event;

    assign counter_enable      = timer_control[`TC_ENABLE_BIT];
    assign clock_source_select = timer_control[`TC_SOURCE_BIT];
    assign prescale_select     = prescale_t'(timer_control[`TC_PRESCALE_MSB:`TC_PRESCALE_LSB]);
    assign count               = {count_high_byte, count_low_byte};
    assign compare_value       = {compare_value_high, compare_value_low};
    assign count_value         = count;

    // ---------------- axi4-lite slave ----------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `OFS_TIMER_CONTROL) || (a == `OFS_GATE_CONTROL) ||
                 (a == `OFS_COUNT_LOW) || (a == `OFS_COUNT_HIGH) ||
                 (a == `OFS_COMPARE_LOW) || (a == `OFS_COMPARE_HIGH) ||
                 (a == `OFS_COMPARE_CONTROL) || (a == `OFS_IRQ_STATUS) ||
                 (a == `OFS_IRQ_MASK);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // all registers are one byte wide, so only lane 0 matters
    function automatic logic hit(input logic [7:0] ofs);
        hit = do_write && (aw_addr == ofs) && w_strb[0];
    endfunction

    assign write_low   = hit(`OFS_COUNT_LOW);
    assign write_high  = hit(`OFS_COUNT_HIGH);
    assign write_gate  = hit(`OFS_GATE_CONTROL);
    assign count_write = write_low || write_high;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            unique case (s_axi_araddr)
                `OFS_TIMER_CONTROL:   s_axi_rdata <= {24'h00_0000, timer_control};
                `OFS_GATE_CONTROL:    s_axi_rdata <= {24'h00_0000, gate_enable, gate_polarity,
                                                      toggle_mode, single_pulse_mode,
                                                      pulse_acquire_go, gate_level_value,
                                                      gate_source};
                `OFS_COUNT_LOW:       s_axi_rdata <= {24'h00_0000, count_low_byte};
                `OFS_COUNT_HIGH:      s_axi_rdata <= {24'h00_0000, count_high_byte};
                `OFS_COMPARE_LOW:     s_axi_rdata <= {24'h00_0000, compare_value_low};
                `OFS_COMPARE_HIGH:    s_axi_rdata <= {24'h00_0000, compare_value_high};
                `OFS_COMPARE_CONTROL: s_axi_rdata <= {30'h0000_0000, special_event_enable,
                                                      compare_mode};
                `OFS_IRQ_STATUS:      s_axi_rdata <= {29'h0000_0000, irq_status};
                `OFS_IRQ_MASK:        s_axi_rdata <= {29'h0000_0000, irq_mask};
                default:              s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- configuration registers ----------------
    // reserved control bits are masked on write so they read as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_control <= `RESET_BYTE;
        end else if (hit(`OFS_TIMER_CONTROL)) begin
            timer_control <= w_data[7:0] & `TC_WRITE_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_enable   <= 1'b0;
            gate_polarity <= 1'b0;
            toggle_mode   <= 1'b0;
            single_pulse_mode <= 1'b0;
            gate_source   <= gate_from_pin1;
        end else if (write_gate) begin
            gate_enable   <= w_data[`GC_ENABLE_BIT];
            gate_polarity <= w_data[`GC_POLARITY_BIT];
            toggle_mode   <= w_data[`GC_TOGGLE_BIT];
            single_pulse_mode <= w_data[`GC_SPM_BIT];
            gate_source   <= gate_source_t'(w_data[`GC_SOURCE_MSB:`GC_SOURCE_LSB]);
        end
    end

    // a software set of go beats a hardware clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_acquire_go <= 1'b0;
        end else if (write_gate) begin
            pulse_acquire_go <= w_data[`GC_GO_BIT] && w_data[`GC_SPM_BIT];
        end else if (!single_pulse_mode || gate_fall) begin
            pulse_acquire_go <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_value_low    <= `RESET_BYTE;
            compare_value_high   <= `RESET_BYTE;
            compare_mode         <= 1'b0;
            special_event_enable <= 1'b0;
            irq_mask             <= `RESET_IRQ;
        end else begin
            if (hit(`OFS_COMPARE_LOW)) begin
                compare_value_low <= w_data[7:0];
            end
            if (hit(`OFS_COMPARE_HIGH)) begin
                compare_value_high <= w_data[7:0];
            end
            if (hit(`OFS_COMPARE_CONTROL)) begin
                compare_mode         <= w_data[`CC_COMPARE_BIT];
                special_event_enable <= w_data[`CC_SPECIAL_BIT];
            end
            if (hit(`OFS_IRQ_MASK)) begin
                irq_mask <= w_data[`IRQ_WIDTH-1:0];
            end
        end
    end

    // ---------------- clock selection and prescale ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inst_div <= 2'h0;
        end else begin
            inst_div <= inst_div + 2'h1;
        end
    end

    assign inst_tick   = (inst_div == `INST_DIV_LAST);
    assign source_tick = clock_source_select ? 1'b1 : inst_tick;

    timer_prescaler #(
        .WIDTH (3)
    ) prescaler (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clear    (count_write),
        .tick_in  (source_tick && counter_enable),
        .ratio    (prescale_select),
        .tick_out (count_tick)
    );

    // ---------------- gate ----------------
    always_comb begin
        unique case (gate_source)
            gate_from_pin1:    gate_raw = gate_pin1;
            gate_from_timer0:  gate_raw = timer0_overflow;
            gate_from_pin2:    gate_raw = gate_pin2;
            gate_from_uv_comp: gate_raw = uv_comparator;
        endcase
    end

    assign gate_active = gate_polarity ? gate_raw : !gate_raw;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_active_q <= 1'b0;
        end else begin
            gate_active_q <= gate_active;
        end
    end

    // held clear when toggle mode is off, so the measured edge is known
    always_ff @(posedge aclk) begin
        if (!aresetn || !counter_enable || !toggle_mode) begin
            gate_toggle <= 1'b0;
        end else if (gate_active && !gate_active_q) begin
            gate_toggle <= !gate_toggle;
        end
    end

    always_comb begin
        next_gate_level = toggle_mode ? gate_toggle : gate_active;
        if (single_pulse_mode) begin
            next_gate_level = next_gate_level && pulse_acquire_go;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_level_value <= 1'b0;
        end else begin
            gate_level_value <= next_gate_level;
        end
    end

    assign gate_fall = gate_level_value && !next_gate_level;

    // ---------------- compare and special event ----------------
    assign match = compare_mode && (count == compare_value);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match;
        end
    end

    // one event per arrival at the compare value
    assign compare_event     = match && !match_q;
    assign special_event_out = compare_event && special_event_enable;
    assign special_clear     = special_event_out || special_event_in;

    // ---------------- counter ----------------
    assign may_count      = count_tick && (!gate_enable || gate_level_value);
    assign overflow_event = may_count && (count == `COUNT_MAX) && !special_clear;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_low_byte  <= `RESET_BYTE;
            count_high_byte <= `RESET_BYTE;
        end else if (count_write) begin
            if (write_low) begin
                count_low_byte <= w_data[7:0];
            end
            if (write_high) begin
                count_high_byte <= w_data[7:0];
            end
        end else if (special_clear) begin
            {count_high_byte, count_low_byte} <= `RESET_WORD;
        end else if (may_count) begin
            {count_high_byte, count_low_byte} <= count + 16'h0001;
        end
    end

    // ---------------- interrupts ----------------
    // a hardware set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= `RESET_IRQ;
        end else begin
            if (hit(`OFS_IRQ_STATUS)) begin
                irq_status <= irq_status & ~w_data[`IRQ_WIDTH-1:0];
            end
            if (overflow_event) begin
                irq_status[`IRQ_OVERFLOW_BIT] <= 1'b1;
            end
            if (gate_fall) begin
                irq_status[`IRQ_GATE_BIT] <= 1'b1;
            end
            if (compare_event) begin
                irq_status[`IRQ_COMPARE_BIT] <= 1'b1;
            end
        end
    end

    assign irq = |(irq_status & irq_mask);

endmodule

`default_nettype wire

//--- timer_trigger_model.sv
// model of the capture/compare unit that sends the special event trigger
// assumes fire is sampled on aclk; each request gives one trigger one aclk wide
`default_nettype none

module timer_trigger_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       fire,
    input  wire logic [1:0] lag,
    output logic            special_event_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pipe;
    // lag picks a delay of one to four aclk cycles; the pulse is never stretched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pipe <= 4'h0;
        end else begin
            pipe <= {pipe[2:0], fire};
        end
    end
    assign special_event_in = pipe[lag];
endmodule

`default_nettype wire

//--- timer_event_reset_chk.sv
// port checks for the event-reset timer: bus answers, counter steps, trigger clear
// assumes one aclk domain with synchronous active-low reset
`default_nettype none

module timer_event_reset_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        special_event_in,
    input wire logic        special_event_out,
    input wire logic [15:0] count_value
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // nothing pending, so no counter byte write can land at the next edge
    logic bus_quiet;
    assign bus_quiet = s_axi_awready && !s_axi_awvalid;
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence trig_alone;
        (special_event_in || special_event_out) && bus_quiet;
    endsequence
    chk_trig_clears:
    assert property (trig_alone |=> count_value == 16'h0000)
        else $error("trigger left the counter nonzero");
    chk_count_step:
    assert property (bus_quiet && !special_event_in && !special_event_out
        |=> count_value == $past(count_value) || count_value == $past(count_value) + 16'h0001)
        else $error("counter moved by other than one");
    chk_event_single:
    assert property (special_event_out |=> !special_event_out)
        else $error("compare event longer than one cycle");
    chk_write_answer:
    assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_b_release:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    chk_read_answer:
    assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    chk_r_release:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not released");
    chk_read_blocks:
    assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    chk_write_blocks:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule

bind timer_event_reset timer_event_reset_chk chk (.*);

`default_nettype wire

//--- timer_event_reset_test.sv
// self-checking bench for the event-reset timer: bus tasks, trigger model, result queue
// assumes timer_cfg.svh offsets and the designer's bus and counter timing
`include "timer_cfg.svh"
`default_nettype none

module timer_event_reset_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, r;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, trig_lag = 2'h0;
    logic        gate_pin1 = 1'b0, gate_pin2 = 1'b0, timer0_overflow = 1'b0;
    logic        uv_comparator = 1'b0, trig_arm = 1'b0, trig_pulse = 1'b0;
    logic        special_event_in, special_event_out, irq;
    logic [15:0] count_value, lfsr = 16'hE956;
    logic [34:0] q[$];
    int          n_errors = 0, checks = 0, n, i;

    always #4 aclk = ~aclk;
    timer_event_reset dut (.*);
    timer_trigger_model cc_unit (.aclk, .aresetn, .lag(trig_lag), .special_event_in,
        .fire(trig_pulse | (trig_arm & s_axi_awvalid & s_axi_awready)));

    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [34:0] seen, input logic [34:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic stall();
        n_errors++;
        $display("mismatch at %0t: wait ran out", $time);
        wrap_up();
    endtask
    // one transfer at a time; valid and payload held until their own ready is seen
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] resp);
        int k;
        logic ta, tw, done;
        q.push_back({rd, resp, rd ? d : 32'h0000_0000});
        @(posedge aclk);
        if (rd) begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end else begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end
        for (k = 0; k < 40; k++) begin
            @(negedge aclk);
            ta = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
            tw = s_axi_wvalid && s_axi_wready;
            done = (s_axi_rready && s_axi_rvalid) || (s_axi_bready && s_axi_bvalid);
            @(posedge aclk);
            if (ta) begin
                s_axi_awvalid <= 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (tw) s_axi_wvalid <= 1'b0;
            if (done) begin
                s_axi_rready <= 1'b0;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (k == 40) stall();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b0, a, {24'h00_0000, d}, `RESP_OKAY);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h00_0000, d}, `RESP_OKAY);
    endtask
    task automatic wait_count(input logic [15:0] v);
        int k;
        for (k = 0; k < 200 && count_value !== v; k++) begin
            @(posedge aclk);
            #1;
        end
        if (k == 200) stall();
    endtask
    task automatic wait_event(output int k);
        for (k = 0; k < 600 && special_event_out !== 1'b1; k++) begin
            @(posedge aclk);
            #1;
        end
        if (k == 600) stall();
    endtask
    // whole periods of the slowest setting fit in 64 cycles, so the delta is exact
    task automatic rate(input logic [7:0] ctrl, input logic [15:0] exp);
        logic [15:0] c0;
        wr(`OFS_TIMER_CONTROL, ctrl);
        repeat (8) @(posedge aclk);
        #1;
        c0 = count_value;
        repeat (64) @(posedge aclk);
        #1;
        check({19'h0, count_value - c0}, {19'h0, exp});
    endtask

    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready)
            check({1'b1, s_axi_rresp, s_axi_rdata}, q.size() > 0 ? q.pop_front() : 35'hx);
        if (s_axi_bvalid && s_axi_bready)
            check({1'b0, s_axi_bresp, 32'h0000_0000}, q.size() > 0 ? q.pop_front() : 35'hx);
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_TIMER_CONTROL, 8'h00);
        rd(`OFS_COUNT_HIGH, 8'h00);
        bus(1'b1, 8'h40, 32'h0000_0000, `RESP_SLVERR);
        bus(1'b0, 8'h40, 32'h0000_00FF, `RESP_SLVERR);
        wr(`OFS_TIMER_CONTROL, 8'hFE);
        rd(`OFS_TIMER_CONTROL, 8'h32);
        for (i = 0; i < 8; i++) begin
            rate({2'b00, i[1:0], 2'b00, i[2], 1'b1}, 16'h0040 >> (i[1:0] + (i[2] ? 0 : 2)));
        end
        rate(8'h02, 16'h0000);
        wr(`OFS_COUNT_HIGH, 8'hFF);
        wr(`OFS_COUNT_LOW, 8'hF0);
        wr(`OFS_TIMER_CONTROL, 8'h03);
        wait_count(16'h0000);
        wr(`OFS_TIMER_CONTROL, 8'h02);
        rd(`OFS_IRQ_STATUS, 8'h01);
        wr(`OFS_IRQ_STATUS, 8'h01);
        rd(`OFS_IRQ_STATUS, 8'h00);
        wr(`OFS_COUNT_HIGH, 8'h12);
        wr(`OFS_COUNT_LOW, 8'h34);
        check({19'h0, count_value}, {19'h0, 16'h1234});
        trig_lag <= 2'h2;
        trig_pulse <= 1'b1;
        @(posedge aclk);
        trig_pulse <= 1'b0;
        wait_count(16'h0000);
        rd(`OFS_IRQ_STATUS, 8'h00);
        trig_lag <= 2'h0;
        wr(`OFS_COUNT_HIGH, 8'h12);
        trig_arm <= 1'b1;
        wr(`OFS_COUNT_LOW, 8'h56);
        trig_arm <= 1'b0;
        check({19'h0, count_value}, {19'h0, 16'h1256});
        lfsr = lfsr_step(lfsr);
        r = lfsr[7:0] | 8'h10;
        wr(`OFS_COUNT_LOW, 8'h00);
        wr(`OFS_COUNT_HIGH, 8'h00);
        wr(`OFS_COMPARE_LOW, r);
        wr(`OFS_COMPARE_HIGH, 8'h00);
        rd(`OFS_COMPARE_LOW, r);
        wr(`OFS_COMPARE_CONTROL, 8'h03);
        wr(`OFS_TIMER_CONTROL, 8'h03);
        wait_event(n);
        check({19'h0, count_value}, {27'h0, r});
        @(posedge aclk);
        #1;
        check({19'h0, count_value}, 35'h0);
        wait_event(n);
        check({26'h0, n[8:0]}, {27'h0, r});
        wr(`OFS_TIMER_CONTROL, 8'h02);
        // trigger lands on the wrap value, so a missed suppression shows as bit 0
        wr(`OFS_COMPARE_LOW, 8'hFF);
        wr(`OFS_COMPARE_HIGH, 8'hFF);
        wr(`OFS_COUNT_HIGH, 8'hFF);
        wr(`OFS_COUNT_LOW, 8'hF0);
        wr(`OFS_TIMER_CONTROL, 8'h03);
        wait_count(16'h0000);
        rd(`OFS_IRQ_STATUS, 8'h04);
        check({34'h0, irq}, 35'h0);
        wr(`OFS_IRQ_MASK, 8'h04);
        check({34'h0, irq}, 35'h1);
        // polarity change drops the gate value once; clear that flag before the pulse
        wr(`OFS_GATE_CONTROL, 8'hD0);
        wr(`OFS_IRQ_STATUS, 8'h06);
        check({34'h0, irq}, 35'h0);
        wr(`OFS_COMPARE_CONTROL, 8'h00);
        wr(`OFS_GATE_CONTROL, 8'hD8);
        wr(`OFS_TIMER_CONTROL, 8'h03);
        gate_pin1 <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(`OFS_GATE_CONTROL, 8'hDC);
        gate_pin1 <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(`OFS_GATE_CONTROL, 8'hD0);
        rd(`OFS_IRQ_STATUS, 8'h02);
        wr(`OFS_GATE_CONTROL, 8'hE0);
        gate_pin1 <= 1'b1;
        wr(`OFS_TIMER_CONTROL, 8'h00);
        rd(`OFS_GATE_CONTROL, 8'hE0);
        wrap_up();
    end
endmodule

`default_nettype wire
